// file: common/ratio_div_if.sv
// link between the timer core and one power-of-two divider stage
`timescale 1ns/100ps
interface ratio_div_if;
   logic                              clear;
   logic                              tick_in;
   logic [timer_pkg::DIV_CODE_W-1:0]  code;
   logic                              tick_out;

   modport divider (input clear, input tick_in, input code, output tick_out);
   modport user    (output clear, output tick_in, output code, input tick_out);
endinterface : ratio_div_if

// file: common/timer_pkg.sv
// shared constants and types of the general purpose timer
package timer_pkg;

   // system clock rate and the synthesized-reference unit (1/64 MHz)
   localparam int unsigned CLK_PERIOD_NS       = 50;
   localparam int unsigned SYS_CLK_KHZ         = 1_000_000 / CLK_PERIOD_NS;
   localparam int unsigned SYNTH_UNITS_PER_MHZ = 64;
   localparam logic [15:0] SYS_CLK_UNITS       = 16'(SYS_CLK_KHZ * SYNTH_UNITS_PER_MHZ / 1000);

   // register byte offsets
   localparam int unsigned APB_ADDR_W   = 8;
   localparam logic [7:0]  OFS_CONTROL    = 8'h00;
   localparam logic [7:0]  OFS_PRESET     = 8'h04;
   localparam logic [7:0]  OFS_START_STOP = 8'h0C;
   localparam logic [7:0]  OFS_RUN_STATUS = 8'h10;
   localparam logic [7:0]  OFS_READBACK   = 8'h14;
   localparam logic [7:0]  OFS_SYNTH_CFG  = 8'h18;
   localparam logic [7:0]  OFS_SYNTH_STS  = 8'h1C;
   localparam logic [7:0]  OFS_IRQ_STS    = 8'h20;
   localparam logic [7:0]  OFS_IRQ_MASK   = 8'h24;

   // timer_control field positions
   localparam int unsigned CTL_CONT_BIT     = 21;
   localparam int unsigned CTL_DIR_BIT      = 20;
   localparam int unsigned CTL_PRESCALE_LSB = 16;
   localparam int unsigned CTL_REFDIV_LSB   = 12;
   localparam int unsigned CTL_FIXSEL_LSB   = 8;
   localparam int unsigned CTL_SRC_LSB      = 0;
   localparam int unsigned DIV_CODE_W       = 3;
   localparam int unsigned SRC_W            = 4;
   localparam logic [31:0] CTL_WRITE_MASK   = 32'h0037_770F;

   // start/stop, status and interrupt bit positions
   localparam int unsigned START_BIT   = 0;
   localparam int unsigned STOP_BIT    = 4;
   localparam int unsigned RUN_BIT     = 0;
   localparam int unsigned IRQ_EOC_BIT = 0;

   // values after reset
   localparam logic [31:0] CONTROL_RST   = 32'h0000_0000;
   localparam logic [31:0] PRESET_RST    = 32'h0000_0000;
   localparam logic [15:0] SYNTH_REQ_RST = 16'h0180;
   localparam logic [15:0] SYNTH_ACH_RST = 16'h0000;

   // reference source codes
   localparam logic [3:0] SRC_SYNTH = 4'h0;
   localparam logic [3:0] SRC_SLOW  = 4'h1;
   localparam logic [3:0] SRC_MASTER_CLOCK_INPUT_ONE = 4'h4;
   localparam logic [3:0] SRC_FIXED = 4'h8;
   localparam logic [3:0] SRC_GENERAL_PIN_TWO = 4'hD;

   // fixed reference frequencies in kHz, codes 000 to 011
   localparam int unsigned FIXED_REF_KHZ [4] = '{6144, 12288, 24576, 49152};

   typedef enum logic {
      RUN_STOPPED = 1'b0,
      RUN_ACTIVE  = 1'b1
   } run_state_e;

endpackage : timer_pkg

// file: rtl/general_purpose_timer.sv
// general purpose timer: reference selection, dividers, up/down counter, APB registers
// Function
// [R01] maximum count is up final, down start value
// [R02] prescale divides reference by two to code
// [R03] reference divider two to code, bypassed source 0
// [R04] software keeps divider output within rate limits
// [R05] divider output times logger when system clock off
// [R06] fixed reference select picks one of four rates
// [R07] software keeps fixed rate below its source
// [R08] source select maps codes to clock inputs
// [R09] configure only while stopped; status shows running
// [R10] start restarts counter, stop halts it
// [R11] live count readable, resets to zero
// [R12] synthesized request in 1/64 MHz, bounded range
// [R13] synthesized request not above system clock
// [R14] synthesized reference by integer system clock division
// [R15] achieved synthesized rate readable, resets to zero
// [R16] continuous bit: stop or reload at end
// [R17] prescaler output steps the counter
// [R18] end interrupt one count period after final
// [R19] single mode holds count and clears running
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module general_purpose_timer
   import timer_pkg::*;
#(
   parameter int unsigned COUNT_W = 32
) (
   input  wire logic                  clk_sys_i,
   input  wire logic                  arst_n_i,
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [APB_ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic      [31:0]           prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   input  wire logic                  slow_clock_i,
   input  wire logic                  master_clock_input_one_i,
   input  wire logic                  general_pin_two_i,
   input  wire logic                  system_clock_enable_i,
   output logic                       irq_o,
   output logic                       timer_status_o,
   output logic                       logger_ref_tick_o
);

   if (COUNT_W < 2 || COUNT_W > 32) begin : g_bad_count_w
      $error("general_purpose_timer: COUNT_W must lie in 2..32");
   end

   typedef struct packed {
      logic [31:0]        ctrl;
      logic [COUNT_W-1:0] preset;
      logic [15:0]        synth_req;
      logic [15:0]        synth_ach;
      logic [15:0]        sys_cnt;
      logic [COUNT_W-1:0] count;
      run_state_e         run;
      logic               irq_sts;
      logic               irq_msk;
      logic [2:0]         src_hist;
      logic               src_tick;
      logic [31:0]        rdata;
      logic               slverr;
   } timer_state_s;

   timer_state_s st_q;
   timer_state_s st_d;

   ratio_div_if refdiv_if ();
   ratio_div_if prescale_if ();

   pow2_divider #(
      .CODE_W (DIV_CODE_W)
   ) u_refdiv (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .div       (refdiv_if)
   );

   pow2_divider #(
      .CODE_W (DIV_CODE_W)
   ) u_prescale (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .div       (prescale_if)
   );

   // a reserved fixed code gives divisor zero, which stops the reference
   function automatic logic [15:0] fixed_divisor(input logic [DIV_CODE_W-1:0] code);
      logic [15:0] n;
      n = 16'h0000;
      if (code[2] == 1'b0) begin
         n = 16'(SYS_CLK_KHZ / FIXED_REF_KHZ[code[1:0]]); // [R06]
         if (n == 16'h0000) begin
            n = 16'h0001; // [R07]
         end
      end
      return n;
   endfunction : fixed_divisor

   logic [SRC_W-1:0]      src_w;
   logic                  dir_up_w;
   logic                  cont_w;
   logic [15:0]           syn_div_w;
   logic [15:0]           sys_div_w;
   logic                  sys_tick_w;
   logic                  raw_tick_w;
   logic                  ref_tick_w;
   logic                  count_tick_w;
   logic [2:0]            src_lvl_w;
   logic [2:0]            src_rise_w;
   logic                  at_final_w;
   logic                  eoc_w;
   logic                  setup_w;
   logic                  wr_w;
   logic                  start_w;
   logic                  stop_w;
   logic                  hit_w;
   logic [31:0]           rd_mux_w;
   logic [COUNT_W-1:0]    initial_w;

   always_comb begin
      src_w    = st_q.ctrl[CTL_SRC_LSB +: SRC_W];
      dir_up_w = st_q.ctrl[CTL_DIR_BIT];
      cont_w   = st_q.ctrl[CTL_CONT_BIT];

      // integer division of the system clock; zero request falls back to the slowest rate
      if (st_q.synth_req == 16'h0000) begin
         syn_div_w = 16'hFFFF; // [R12]
      end else begin
         syn_div_w = SYS_CLK_UNITS / st_q.synth_req; // [R14]
      end
      if (syn_div_w == 16'h0000) begin
         syn_div_w = 16'h0001; // [R13]
      end
      sys_div_w  = (src_w == SRC_SYNTH) ? syn_div_w : fixed_divisor(st_q.ctrl[CTL_FIXSEL_LSB +: DIV_CODE_W]);
      sys_tick_w = (sys_div_w != 16'h0000) && (st_q.sys_cnt >= sys_div_w - 16'h0001);

      // external sources are synchronous levels; count their rising edges
      src_lvl_w  = {general_pin_two_i, master_clock_input_one_i, slow_clock_i};
      src_rise_w = src_lvl_w & ~st_q.src_hist;

      case (src_w)
         SRC_SYNTH, SRC_FIXED: raw_tick_w = sys_tick_w; // [R08]
         SRC_SLOW:             raw_tick_w = src_rise_w[0]; // [R08]
         SRC_MASTER_CLOCK_INPUT_ONE:            raw_tick_w = src_rise_w[1]; // [R08]
         SRC_GENERAL_PIN_TWO:            raw_tick_w = src_rise_w[2]; // [R08]
         default:              raw_tick_w = 1'b0;
      endcase

      ref_tick_w   = (src_w == SRC_SYNTH) ? st_q.src_tick : refdiv_if.tick_out; // [R03]
      count_tick_w = prescale_if.tick_out; // [R17]

      initial_w  = dir_up_w ? '0 : st_q.preset; // [R01]
      at_final_w = dir_up_w ? (st_q.count == st_q.preset) : (st_q.count == '0); // [R01]

      // bus decode
      setup_w = psel_i && !penable_i;
      wr_w    = psel_i && penable_i && pwrite_i && !st_q.slverr;
      hit_w   = 1'b1;
      case (paddr_i)
         OFS_CONTROL:    rd_mux_w = st_q.ctrl;
         OFS_PRESET:     rd_mux_w = 32'(st_q.preset);
         OFS_START_STOP: rd_mux_w = 32'h0000_0000;
         OFS_RUN_STATUS: rd_mux_w = 32'(st_q.run); // [R09]
         OFS_READBACK:   rd_mux_w = 32'(st_q.count); // [R11]
         OFS_SYNTH_CFG:  rd_mux_w = {16'h0000, st_q.synth_req};
         OFS_SYNTH_STS:  rd_mux_w = {16'h0000, st_q.synth_ach}; // [R15]
         OFS_IRQ_STS:    rd_mux_w = 32'(st_q.irq_sts);
         OFS_IRQ_MASK:   rd_mux_w = 32'(st_q.irq_msk);
         default: begin
            rd_mux_w = 32'h0000_0000;
            hit_w    = 1'b0;
         end
      endcase
      start_w = wr_w && (paddr_i == OFS_START_STOP) && pwdata_i[START_BIT];
      stop_w  = wr_w && (paddr_i == OFS_START_STOP) && pwdata_i[STOP_BIT];
      eoc_w   = (st_q.run == RUN_ACTIVE) && count_tick_w && at_final_w && !start_w && !stop_w; // [R18]

      // divider stages are restarted with the counter so the first period is whole
      refdiv_if.clear     = start_w;
      refdiv_if.tick_in   = st_q.src_tick;
      refdiv_if.code      = st_q.ctrl[CTL_REFDIV_LSB +: DIV_CODE_W];
      prescale_if.clear   = start_w;
      prescale_if.tick_in = ref_tick_w;
      prescale_if.code    = st_q.ctrl[CTL_PRESCALE_LSB +: DIV_CODE_W]; // [R02]

      st_d          = st_q;
      st_d.src_hist = src_lvl_w;
      st_d.src_tick = raw_tick_w;
      st_d.sys_cnt  = (sys_tick_w || start_w) ? 16'h0000 : st_q.sys_cnt + 16'h0001;
      if (src_w == SRC_SYNTH) begin
         st_d.synth_ach = SYS_CLK_UNITS / syn_div_w; // [R15]
      end

      if (setup_w) begin
         st_d.rdata  = rd_mux_w;
         st_d.slverr = !hit_w;
      end

      if (wr_w) begin
         case (paddr_i)
            OFS_CONTROL:   st_d.ctrl      = pwdata_i & CTL_WRITE_MASK;
            OFS_PRESET:    st_d.preset    = pwdata_i[COUNT_W-1:0];
            OFS_SYNTH_CFG: st_d.synth_req = pwdata_i[15:0];
            OFS_IRQ_MASK:  st_d.irq_msk   = pwdata_i[IRQ_EOC_BIT];
            default: begin
            end
         endcase
      end

      // stop wins over a start written in the same word
      if (stop_w) begin
         st_d.run = RUN_STOPPED; // [R10]
      end else if (start_w) begin
         st_d.run   = RUN_ACTIVE; // [R10]
         st_d.count = initial_w; // [R10]
      end else if (st_q.run == RUN_ACTIVE && count_tick_w) begin
         if (at_final_w) begin
            if (cont_w) begin
               st_d.count = initial_w; // [R16]
            end else begin
               st_d.run = RUN_STOPPED; // [R19]
            end
         end else if (dir_up_w) begin
            st_d.count = st_q.count + 1'b1; // [R17]
         end else begin
            st_d.count = st_q.count - 1'b1; // [R17]
         end
      end

      // a new end of count beats a clear in the same cycle
      if (wr_w && paddr_i == OFS_IRQ_STS && pwdata_i[IRQ_EOC_BIT]) begin
         st_d.irq_sts = 1'b0;
      end
      if (eoc_w) begin
         st_d.irq_sts = 1'b1; // [R18]
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q           <= '0;
         st_q.ctrl      <= CONTROL_RST;
         st_q.preset    <= PRESET_RST[COUNT_W-1:0];
         st_q.synth_req <= SYNTH_REQ_RST;
         st_q.synth_ach <= SYNTH_ACH_RST;
         st_q.run       <= RUN_STOPPED;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata_o          = st_q.rdata;
   assign pready_o          = 1'b1;
   assign pslverr_o         = st_q.slverr;
   assign irq_o             = st_q.irq_sts & st_q.irq_msk;
   assign timer_status_o    = (st_q.run == RUN_ACTIVE);
   // the logger only takes the divided reference while the system clock is off
   assign logger_ref_tick_o = ref_tick_w & ~system_clock_enable_i; // [R05]

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   sequence start_seq;
      start_w && !stop_w;
   endsequence

   sequence final_step_seq;
      (st_q.run == RUN_ACTIVE) && count_tick_w && at_final_w && !start_w && !stop_w;
   endsequence

   sequence mid_step_seq;
      (st_q.run == RUN_ACTIVE) && count_tick_w && !at_final_w && !start_w && !stop_w;
   endsequence

   start_up_zero_a: assert property ((start_seq and dir_up_w) // [R10]
      |=> (st_q.count == '0 && st_q.run == RUN_ACTIVE)) else $error("up start did not begin at zero");
   start_down_max_a: assert property ((start_seq and !dir_up_w) // [R01]
      |=> (st_q.count == $past(st_q.preset) && st_q.run == RUN_ACTIVE)) else $error("down start not at max");
   stop_halts_a: assert property (stop_w |=> (st_q.run == RUN_STOPPED) ##1 $stable(st_q.count)) // [R10]
      else $error("stop did not halt the counter");
   step_size_a: assert property (mid_step_seq // [R17]
      |=> (st_q.count == ($past(dir_up_w) ? $past(st_q.count) + 1'b1 : $past(st_q.count) - 1'b1)))
      else $error("counter did not step by one");
   idle_hold_a: assert property ((!count_tick_w && !start_w) |=> $stable(st_q.count)) // [R17]
      else $error("counter moved without a count tick");
   eoc_late_a: assert property (final_step_seq |=> st_q.irq_sts) // [R18]
      else $error("end of count missing one period after final");
   eoc_not_early_a: assert property ((mid_step_seq and !st_q.irq_sts) ##1 !wr_w |-> !st_q.irq_sts) // [R18]
      else $error("end of count raised before the final period ended");
   single_hold_a: assert property ((final_step_seq and !cont_w) // [R19]
      |=> (st_q.run == RUN_STOPPED && st_q.count == $past(st_q.count))) else $error("single mode did not hold");
   cont_reload_a: assert property ((final_step_seq and cont_w) // [R16]
      |=> (st_q.run == RUN_ACTIVE && st_q.count == $past(initial_w))) else $error("continuous reload failed");
   status_read_a: assert property ((setup_w && paddr_i == OFS_RUN_STATUS) // [R09]
      |=> prdata_o == 32'($past(st_q.run))) else $error("running status readback wrong");
   readback_a: assert property ((setup_w && paddr_i == OFS_READBACK) // [R11]
      |=> prdata_o == 32'($past(st_q.count))) else $error("live count readback wrong");
   synth_ach_a: assert property ((src_w == SRC_SYNTH && $stable(st_q.synth_req)) ##1 (src_w == SRC_SYNTH) // [R15]
      |-> (st_q.synth_ach <= SYS_CLK_UNITS && st_q.synth_ach != 16'h0000)) else $error("achieved rate out of range");
   bypass_a: assert property ((src_w == SRC_SYNTH) |-> (prescale_if.tick_in == st_q.src_tick)) // [R03]
      else $error("reference divider not bypassed for source 0");

endmodule : general_purpose_timer

// file: rtl/pow2_divider.sv
// divides a stream of enable pulses by two raised to a code
`timescale 1ns/100ps
module pow2_divider
   import timer_pkg::*;
#(
   parameter int unsigned CODE_W = DIV_CODE_W
) (
   input  wire logic    clk_sys_i,
   input  wire logic    arst_n_i,
   ratio_div_if.divider div
);

   localparam int unsigned CNT_W = (1 << CODE_W) - 1;

   if (CODE_W != DIV_CODE_W) begin : g_bad_code_w
      $error("pow2_divider: CODE_W must match the interface code width");
   end

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             out;
   } div_state_s;

   div_state_s       st_q;
   div_state_s       st_d;
   logic [CNT_W-1:0] last_w;

   always_comb begin
      st_d     = st_q;
      st_d.out = 1'b0;
      last_w   = CNT_W'((1 << div.code) - 1);
      if (div.clear) begin
         st_d.cnt = '0;
      end else if (div.tick_in) begin
         if (st_q.cnt >= last_w) begin
            st_d.cnt = '0;
            st_d.out = 1'b1;
         end else begin
            st_d.cnt = st_q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign div.tick_out = st_q.out;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   div_wrap_a: assert property ((div.tick_in && !div.clear && st_q.cnt == last_w) // [R02]
      |=> (div.tick_out && st_q.cnt == '0)) else $error("divider did not wrap at its ratio");
   div_quiet_a: assert property ((!div.tick_in || div.clear || st_q.cnt < last_w) // [R02]
      |=> !div.tick_out) else $error("divider pulsed early");

endmodule : pow2_divider

// file: tb/general_purpose_timer_bench.sv
// self-checking bench of the general purpose timer over its apb port
`timescale 1ns/100ps
module general_purpose_timer_bench;
   import timer_pkg::*;
   localparam logic [31:0] GO   = 32'h0000_0001 << START_BIT;
   localparam logic [31:0] HALT = 32'h0000_0001 << STOP_BIT;
   logic        clk      = 1'b0;
   logic        arst_n   = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic [2:0]  src_pins = 3'b000;
   logic        sys_en   = 1'b1;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        run_out;
   logic        log_tick;
   int          error_cnt   = 0;
   int          comparisons = 0;
   int          log_cnt     = 0;

   general_purpose_timer i_general_purpose_timer (
      .clk_sys_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .slow_clock_i(src_pins[0]), .master_clock_input_one_i(src_pins[1]), .general_pin_two_i(src_pins[2]),
      .system_clock_enable_i(sys_en), .irq_o(irq), .timer_status_o(run_out), .logger_ref_tick_o(log_tick));

   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   always @(posedge clk) begin
      if (log_tick === 1'b1) log_cnt <= log_cnt + 1;
   end

   task automatic print_verdict;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t ns: seen 0x%08h expected 0x%08h", $time, seen, exp);
      end
   endtask : check

   // request held until pready is seen high at a rising edge, or until 20 further cycles have passed
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n == 20) error_cnt++;
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      check(r, exp);
      check({31'h0, e}, {31'h0, err});
   endtask : rd_chk

   function automatic logic [31:0] ctl(input logic cont, input logic dir, input logic [2:0] pre,
                                       input logic [2:0] div, input logic [2:0] fix, input logic [3:0] src);
      return (32'(cont) << CTL_CONT_BIT) | (32'(dir) << CTL_DIR_BIT) | (32'(pre) << CTL_PRESCALE_LSB)
           | (32'(div) << CTL_REFDIV_LSB) | (32'(fix) << CTL_FIXSEL_LSB) | (32'(src) << CTL_SRC_LSB);
   endfunction : ctl

   // edges spaced three cycles apart keep the source at a third of the system clock
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         @(posedge clk);
         src_pins[idx] <= 1'b1;
         @(posedge clk);
         src_pins[idx] <= 1'b0;
         @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask : pulse

   task automatic irq_chk(input logic exp);
      @(posedge clk);
      check({31'h0, irq}, {31'h0, exp});
   endtask : irq_chk

   task automatic t_reset;
      logic [7:0]  ofs [9] = '{OFS_CONTROL, OFS_PRESET, OFS_START_STOP, OFS_RUN_STATUS, OFS_READBACK,
                               OFS_SYNTH_CFG, OFS_SYNTH_STS, OFS_IRQ_STS, OFS_IRQ_MASK};
      // source 0 is selected out of reset, so the achieved rate follows the reset request at once
      logic [31:0] val [9] = '{CONTROL_RST, PRESET_RST, 32'h0, 32'h0, 32'h0, {16'h0, SYNTH_REQ_RST},
                               32'(SYS_CLK_UNITS / (SYS_CLK_UNITS / SYNTH_REQ_RST)), 32'h0, 32'h0};
      for (int i = 0; i < 9; i++) rd_chk(ofs[i], val[i], 1'b0);
      rd_chk(8'h08, 32'h0, 1'b1);
      rd_chk(8'h05, 32'h0, 1'b1);
      rd_chk(8'h28, 32'h0, 1'b1);
      wr(OFS_PRESET, 32'hA5A5_5A5A);
      rd_chk(OFS_PRESET, 32'hA5A5_5A5A, 1'b0);
      wr(OFS_READBACK, 32'h1234_5678);
      rd_chk(OFS_READBACK, 32'h0000_0000, 1'b0);
   endtask : t_reset

   task automatic t_sources;
      logic [3:0] src [6] = '{SRC_SLOW, SRC_MASTER_CLOCK_INPUT_ONE, SRC_GENERAL_PIN_TWO, SRC_SLOW, SRC_SLOW, 4'h2};
      int pin [6] = '{0, 1, 2, 0, 0, 0};
      int pre [6] = '{0, 1, 2, 7, 0, 0};
      int div [6] = '{0, 1, 0, 0, 7, 0};
      int np  [6] = '{8, 8, 8, 128, 128, 8};
      logic [31:0] r;
      logic        e;
      int          base;
      sys_en <= 1'b0;
      wr(OFS_PRESET, 32'hFFFF_FFFF);
      for (int i = 0; i < 6; i++) begin
         wr(OFS_CONTROL, ctl(1'b0, 1'b1, 3'(pre[i]), 3'(div[i]), 3'd0, src[i]));
         wr(OFS_START_STOP, GO);
         base = log_cnt;
         pulse(pin[i], np[i]);
         apb(1'b0, OFS_READBACK, 32'h0, r, e);
         check(r, (i == 5) ? 32'h0 : 32'(np[i] >> (pre[i] + div[i])));
         check(32'(log_cnt - base), (i == 5) ? 32'h0 : 32'(np[i] >> div[i]));
         wr(OFS_START_STOP, HALT);
      end
      sys_en <= 1'b1;
   endtask : t_sources

   task automatic t_single;
      wr(OFS_CONTROL, ctl(1'b0, 1'b1, 3'd0, 3'd0, 3'd0, SRC_SLOW));
      wr(OFS_PRESET, 32'h0000_0002);
      wr(OFS_START_STOP, GO);
      rd_chk(OFS_READBACK, 32'h0000_0000, 1'b0);
      pulse(0, 2);
      rd_chk(OFS_READBACK, 32'h0000_0002, 1'b0);
      rd_chk(OFS_RUN_STATUS, 32'h0000_0001, 1'b0);
      rd_chk(OFS_IRQ_STS, 32'h0000_0000, 1'b0);
      pulse(0, 1);
      rd_chk(OFS_IRQ_STS, 32'h0000_0001, 1'b0);
      rd_chk(OFS_RUN_STATUS, 32'h0000_0000, 1'b0);
      check({31'h0, run_out}, 32'h0000_0000);
      irq_chk(1'b0);
      pulse(0, 2);
      rd_chk(OFS_READBACK, 32'h0000_0002, 1'b0);
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      irq_chk(1'b1);
      wr(OFS_IRQ_STS, 32'h0000_0001);
      irq_chk(1'b0);
      rd_chk(OFS_IRQ_STS, 32'h0000_0000, 1'b0);
   endtask : t_single

   task automatic t_down;
      wr(OFS_CONTROL, ctl(1'b1, 1'b0, 3'd0, 3'd0, 3'd0, SRC_SLOW));
      wr(OFS_PRESET, 32'h0000_0003);
      wr(OFS_START_STOP, GO);
      rd_chk(OFS_READBACK, 32'h0000_0003, 1'b0);
      pulse(0, 3);
      rd_chk(OFS_READBACK, 32'h0000_0000, 1'b0);
      rd_chk(OFS_IRQ_STS, 32'h0000_0000, 1'b0);
      irq_chk(1'b0);
      pulse(0, 1);
      rd_chk(OFS_READBACK, 32'h0000_0003, 1'b0);
      rd_chk(OFS_RUN_STATUS, 32'h0000_0001, 1'b0);
      irq_chk(1'b1);
      pulse(0, 1);
      rd_chk(OFS_READBACK, 32'h0000_0002, 1'b0);
      wr(OFS_START_STOP, GO);
      rd_chk(OFS_READBACK, 32'h0000_0003, 1'b0);
      pulse(0, 1);
      wr(OFS_START_STOP, HALT);
      rd_chk(OFS_RUN_STATUS, 32'h0000_0000, 1'b0);
      pulse(0, 2);
      rd_chk(OFS_READBACK, 32'h0000_0002, 1'b0);
      wr(OFS_START_STOP, GO | HALT);
      rd_chk(OFS_RUN_STATUS, 32'h0000_0000, 1'b0);
      wr(OFS_IRQ_STS, 32'h0000_0001);
      irq_chk(1'b0);
   endtask : t_down

   // requests stay within 12288 kHz and the system clock rate
   task automatic t_ref;
      logic [3:0]  src [6] = '{SRC_FIXED, SRC_FIXED, SRC_FIXED, SRC_FIXED, SRC_SYNTH, SRC_SYNTH};
      logic [2:0]  fix [6] = '{3'd0, 3'd0, 3'd1, 3'd5, 3'd0, 3'd0};
      logic [2:0]  div [6] = '{3'd0, 3'd1, 3'd1, 3'd0, 3'd0, 3'd0};
      logic [15:0] req [6] = '{16'h0180, 16'h0180, 16'h0180, 16'h0180, 16'h0200, 16'h0180};
      int          tk  [6] = '{20, 10, 30, 0, 30, 20};
      int          base;
      sys_en <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         wr(OFS_SYNTH_CFG, {16'h0, req[i]});
         wr(OFS_CONTROL, ctl(1'b0, 1'b1, 3'd0, div[i], fix[i], src[i]));
         wr(OFS_START_STOP, GO);
         repeat (4) @(posedge clk);
         base = log_cnt;
         repeat (60) @(posedge clk);
         check(32'(log_cnt - base), 32'(tk[i]));
         if (src[i] == SRC_SYNTH)
            rd_chk(OFS_SYNTH_STS, 32'(SYS_CLK_UNITS / (SYS_CLK_UNITS / req[i])), 1'b0);
         wr(OFS_START_STOP, HALT);
      end
      sys_en <= 1'b1;
   endtask : t_ref

   task automatic done(input string name);
      $display("test %s finished, errors so far %0d", name, error_cnt);
   endtask : done

   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      t_reset;
      done("reset");
      t_sources;
      done("sources");
      t_single;
      done("single");
      t_down;
      done("down");
      t_ref;
      done("reference");
      print_verdict;
   end

   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      $display("ERROR at %0t ns: watchdog expired, seen 0x0 expected 0x1", $time);
      print_verdict;
   end
endmodule : general_purpose_timer_bench
